// ### logic/alu_rsds_defs.svh
`ifndef ALU_RSDS_DEFS_SVH
`define ALU_RSDS_DEFS_SVH
`define DATA_W 8
`define BIT_SEL_W 3
`define ALL_ONES 8'hff
`define ONE_BYTE 8'h01
`define ZERO_BYTE 8'h00
`define NIBBLE_MSB 4
`define SIGN_BIT 7
`define CARRY_OUT_BIT 0
`define SHIFT_FROM_BIT 1
`define WORK_RESET 8'h00
`endif

// ### logic/alu_rsds_pkg.sv
package alu_rsds_pkg;
  // Operation codes issued by the instruction sequencer.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ROTATE_RIGHT_CARRY_WORK,
    OP_SUB_BORROW,
    OP_SUB_BORROW_MEM,
    OP_DEC_SKIP_ZERO_MEM,
    OP_DEC_SKIP_ZERO_WORK,
    OP_SET_BYTE,
    OP_SET_BIT
  } op_type;
  // Cycle state of the executer.
  typedef enum logic {
    ST_EXEC,
    ST_DUMMY
  } state_type;
endpackage

// ### logic/alu_rsds.sv
`timescale 1ns/10ps
`include "alu_rsds_defs.svh"
module alu_rsds #(
  parameter int DATA_W = `DATA_W
) (
  input wire logic clock, // Core clock, 100 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic opValid, // One-cycle pulse: an operation is issued.
  input wire alu_rsds_pkg::op_type opCode, // Operation to execute.
  input wire logic [`BIT_SEL_W-1:0] bitSel, // Bit position for single-bit set.
  input wire logic [DATA_W-1:0] memOperand, // Addressed memory byte as read.
  output logic [DATA_W-1:0] memWrData, // Byte to store into memory.
  output logic memWrEn, // Pulse: store memWrData at the addressed byte.
  output logic [DATA_W-1:0] workReg, // Work register.
  output logic carryFlag, // Carry flag.
  output logic zeroFlag, // Zero flag.
  output logic halfCarryFlag, // Half-carry flag.
  output logic signedWrapFlag, // Signed overflow flag.
  output logic skipNext, // Pulse: discard the next fetched instruction.
  output logic busy // High during the inserted dummy cycle.
);
  // Refuses a datapath width that the byte-wide constants cannot serve.
  if (DATA_W != `DATA_W) begin : g_width_check
    $error("alu_rsds supports only an 8-bit datapath.");
  end

  // ==========================================================
  // State
  logic [DATA_W-1:0] work_r, work_nxt;
  logic [DATA_W-1:0] memWr_r, memWr_nxt;
  logic memWrEn_r, memWrEn_nxt;
  logic carry_r, carry_nxt;
  logic zero_r, zero_nxt;
  logic half_r, half_nxt;
  logic wrap_r, wrap_nxt;
  logic skip_r, skip_nxt;
  logic busy_r, busy_nxt;
  alu_rsds_pkg::state_type state_r, state_nxt;

  // ==========================================================
  // Arithmetic helpers
  logic [DATA_W:0] subFull;
  logic [`NIBBLE_MSB:0] subLow;
  logic [DATA_W-1:0] subRes;
  logic [DATA_W-1:0] decRes;
  logic borrowIn;

  // Subtraction with borrow and decrement results.
  always_comb begin
    borrowIn = ~carry_r;
    subFull = {1'b0, work_r} - {1'b0, memOperand} - {{DATA_W{1'b0}}, borrowIn};
    subLow = {1'b0, work_r[`NIBBLE_MSB-1:0]} - {1'b0, memOperand[`NIBBLE_MSB-1:0]}
      - {{`NIBBLE_MSB{1'b0}}, borrowIn};
    subRes = subFull[DATA_W-1:0];
    decRes = memOperand - `ONE_BYTE;
  end

  // ==========================================================
  // Operation decode
  logic opTaken;
  logic isRotate, isSubWork, isSubMem, isDecMem, isDecWork, isSetByte, isSetBit;
  logic decZero;

  // One select per operation; an issue during the dummy cycle selects nothing.
  always_comb begin
    opTaken = opValid && (state_r == alu_rsds_pkg::ST_EXEC);
    isRotate = 1'b0;
    isSubWork = 1'b0;
    isSubMem = 1'b0;
    isDecMem = 1'b0;
    isDecWork = 1'b0;
    isSetByte = 1'b0;
    isSetBit = 1'b0;
    if (opTaken) begin
      case (opCode)
        alu_rsds_pkg::OP_ROTATE_RIGHT_CARRY_WORK: begin
          isRotate = 1'b1;
        end
        alu_rsds_pkg::OP_SUB_BORROW: begin
          isSubWork = 1'b1;
        end
        alu_rsds_pkg::OP_SUB_BORROW_MEM: begin
          isSubMem = 1'b1;
        end
        alu_rsds_pkg::OP_DEC_SKIP_ZERO_MEM: begin
          isDecMem = 1'b1;
        end
        alu_rsds_pkg::OP_DEC_SKIP_ZERO_WORK: begin
          isDecWork = 1'b1;
        end
        alu_rsds_pkg::OP_SET_BYTE: begin
          isSetByte = 1'b1;
        end
        alu_rsds_pkg::OP_SET_BIT: begin
          isSetBit = 1'b1;
        end
        default: begin
          isRotate = 1'b0; // No operation: nothing is selected.
        end
      endcase
    end
    decZero = (decRes == `ZERO_BYTE);
  end

  // ==========================================================
  // Work register and status flags
  // Only a rotate, a subtract or a decrement to work touches this group.
  always_comb begin
    work_nxt = work_r;
    carry_nxt = carry_r;
    zero_nxt = zero_r;
    half_nxt = half_r;
    wrap_nxt = wrap_r;
    if (isRotate) begin
      work_nxt = {carry_r, memOperand[DATA_W-1:`SHIFT_FROM_BIT]};
      carry_nxt = memOperand[`CARRY_OUT_BIT];
    end
    if (isSubWork) begin
      work_nxt = subRes;
    end
    // Both subtract variants update all four flags the same way.
    if (isSubWork || isSubMem) begin
      carry_nxt = ~subFull[DATA_W];
      half_nxt = ~subLow[`NIBBLE_MSB];
      zero_nxt = (subRes == `ZERO_BYTE);
      wrap_nxt = (work_r[`SIGN_BIT] != memOperand[`SIGN_BIT])
        && (subRes[`SIGN_BIT] != work_r[`SIGN_BIT]);
    end
    if (isDecWork) begin
      work_nxt = decRes;
    end
  end

  // Registers the work register and the flags; reset clears them.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      work_r <= `WORK_RESET;
      carry_r <= 1'b0;
      zero_r <= 1'b0;
      half_r <= 1'b0;
      wrap_r <= 1'b0;
    end else begin
      work_r <= work_nxt;
      carry_r <= carry_nxt;
      zero_r <= zero_nxt;
      half_r <= half_nxt;
      wrap_r <= wrap_nxt;
    end
  end

  // ==========================================================
  // Memory store
  // A store strobe lasts one cycle; the data byte holds until the next store.
  always_comb begin
    memWr_nxt = memWr_r;
    memWrEn_nxt = 1'b0;
    if (isSubMem) begin
      memWr_nxt = subRes;
      memWrEn_nxt = 1'b1;
    end
    if (isDecMem) begin
      memWr_nxt = decRes;
      memWrEn_nxt = 1'b1;
    end
    if (isSetByte) begin
      memWr_nxt = `ALL_ONES;
      memWrEn_nxt = 1'b1;
    end
    if (isSetBit) begin
      memWr_nxt = memOperand | (`ONE_BYTE << bitSel);
      memWrEn_nxt = 1'b1;
    end
  end

  // Registers the store data and strobe.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      memWr_r <= `ZERO_BYTE;
      memWrEn_r <= 1'b0;
    end else begin
      memWr_r <= memWr_nxt;
      memWrEn_r <= memWrEn_nxt;
    end
  end

  // ==========================================================
  // Sequencing
  // A zero decrement raises the skip pulse and spends one dummy cycle.
  always_comb begin
    state_nxt = alu_rsds_pkg::ST_EXEC;
    skip_nxt = 1'b0;
    busy_nxt = 1'b0;
    case (state_r)
      alu_rsds_pkg::ST_EXEC: begin
        if ((isDecMem || isDecWork) && decZero) begin
          state_nxt = alu_rsds_pkg::ST_DUMMY;
          skip_nxt = 1'b1;
          busy_nxt = 1'b1;
        end else begin
          state_nxt = alu_rsds_pkg::ST_EXEC;
        end
      end
      alu_rsds_pkg::ST_DUMMY: begin
        state_nxt = alu_rsds_pkg::ST_EXEC;
      end
      default: begin
        state_nxt = alu_rsds_pkg::ST_EXEC;
      end
    endcase
  end

  // Registers the sequencing state; the busy flop mirrors the dummy state.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      skip_r <= 1'b0;
      busy_r <= 1'b0;
      state_r <= alu_rsds_pkg::ST_EXEC;
    end else begin
      skip_r <= skip_nxt;
      busy_r <= busy_nxt;
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // Outputs come straight from the flip-flops.
  assign workReg = work_r;
  assign memWrData = memWr_r;
  assign memWrEn = memWrEn_r;
  assign carryFlag = carry_r;
  assign zeroFlag = zero_r;
  assign halfCarryFlag = half_r;
  assign signedWrapFlag = wrap_r;
  assign skipNext = skip_r;
  assign busy = busy_r;
endmodule

// ### sim/alu_rsds_mem.sv
`timescale 1ns/10ps
// ==========
// Data memory byte standing behind the block.
module alu_rsds_mem (
  input wire logic clock, // Core clock.
  input wire logic ld, // Preload strobe from the bench.
  input wire logic [7:0] ldVal, // Preload value.
  input wire logic memWrEn, // Store strobe from the block.
  input wire logic [7:0] memWrData, // Store data.
  output logic [7:0] memOperand // Byte as read.
);
  logic [7:0] mem_r = 8'h00;
  logic [7:0] mem_nxt;
  // A preload wins over a store.
  always_comb begin
    mem_nxt = ld ? ldVal : (memWrEn ? memWrData : mem_r);
  end
  // Holds the byte.
  always_ff @(posedge clock) begin
    mem_r <= mem_nxt;
  end
  assign memOperand = mem_r;
endmodule

// ### sim/alu_rsds_assertions.sv
`timescale 1ns/10ps
module alu_rsds_assertions (
  input wire logic clock, // Core clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic opValid, // Issue strobe.
  input wire alu_rsds_pkg::op_type opCode, // Operation.
  input wire logic [2:0] bitSel, // Bit index.
  input wire logic [7:0] memOperand, // Memory byte.
  input wire logic [7:0] memWrData, // Store data.
  input wire logic memWrEn, // Store strobe.
  input wire logic [7:0] workReg, // Work register.
  input wire logic carryFlag, // Carry.
  input wire logic zeroFlag, // Zero flag.
  input wire logic halfCarryFlag, // Half-carry flag.
  input wire logic signedWrapFlag, // Signed overflow flag.
  input wire logic skipNext, // Skip pulse.
  input wire logic busy // Dummy cycle.
);
  // ==========
  // One-hot view of an accepted operation, indexed by its code.
  logic [7:0] t;
  assign t = {7'h00, opValid & ~busy} << opCode;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_rot_work: assert property (t[1] |=> workReg == {$past(carryFlag), $past(memOperand[7:1])})
    else $error("rotate result wrong");
  a_rot_quiet: assert property (t[1] |=> !memWrEn && !skipNext && carryFlag == $past(memOperand[0]))
    else $error("rotate side effect");
  a_sub_work: assert property (t[2] |=> workReg == $past(workReg - memOperand - {7'h00, ~carryFlag}))
    else $error("subtract result wrong");
  a_sub_mem: assert property (t[3] |=> memWrEn && $stable(workReg) &&
    memWrData == $past(workReg - memOperand - {7'h00, ~carryFlag})) else $error("subtract store wrong");
  a_sub_carry: assert property (t[2] | t[3] |=>
    carryFlag == $past({1'b0, workReg} >= {1'b0, memOperand} + {8'h00, ~carryFlag})) else $error("borrow wrong");
  a_dec_mem: assert property (t[4] |=> memWrEn && memWrData == $past(memOperand - 8'h01) &&
    skipNext == ($past(memOperand) == 8'h01) && $stable(carryFlag)) else $error("decrement store wrong");
  a_sub_zero: assert property (t[2] | t[3] |=>
    zeroFlag == ($past(workReg - memOperand - {7'h00, ~carryFlag}) == 8'h00)) else $error("zero flag wrong");
  a_sub_half: assert property (t[2] | t[3] |=>
    halfCarryFlag == $past({1'b0, workReg[3:0]} >= {1'b0, memOperand[3:0]} + {4'h0, ~carryFlag}))
    else $error("half carry wrong");
  a_flags_kept: assert property (t[1] | t[4] | t[5] | t[6] | t[7] |=> $stable(zeroFlag) &&
    $stable(halfCarryFlag) && $stable(signedWrapFlag)) else $error("flags disturbed");
  a_skip_dummy: assert property (skipNext |-> busy ##1 !busy && !skipNext)
    else $error("dummy cycle wrong");
  a_dec_work: assert property (t[5] |=> !memWrEn && workReg == $past(memOperand - 8'h01) &&
    skipNext == ($past(memOperand) == 8'h01) && $stable(carryFlag)) else $error("decrement to work wrong");
  a_set_byte: assert property (t[6] |=> memWrEn && memWrData == 8'hff && $stable(carryFlag))
    else $error("byte set wrong");
  a_set_bit: assert property (t[7] |=> memWrEn && $stable(carryFlag) &&
    memWrData == ($past(memOperand) | (8'h01 << $past(bitSel)))) else $error("bit set wrong");
endmodule
bind alu_rsds alu_rsds_assertions chk (.clock(clock), .rst_n(rst_n), .opValid(opValid), .opCode(opCode),
  .bitSel(bitSel), .memOperand(memOperand), .memWrData(memWrData), .memWrEn(memWrEn), .workReg(workReg),
  .carryFlag(carryFlag), .zeroFlag(zeroFlag), .halfCarryFlag(halfCarryFlag), .signedWrapFlag(signedWrapFlag),
  .skipNext(skipNext), .busy(busy));

// ### sim/alu_rsds_test.sv
`timescale 1ns/10ps
module alu_rsds_test;
  logic clock = 0, rst_n = 0, opValid = 0, ld = 0;
  alu_rsds_pkg::op_type opCode = alu_rsds_pkg::OP_NONE;
  logic [2:0] bitSel = 3'h0;
  logic [7:0] ldVal = 8'h00, memOperand, memWrData, workReg;
  logic memWrEn, carryFlag, skipNext, busy, zeroFlag, halfCarryFlag, signedWrapFlag;
  int errors = 0, checks = 0;
  logic [39:0] rows [14];
  always #5 clock = ~clock;
  alu_rsds dut (.clock(clock), .rst_n(rst_n), .opValid(opValid), .opCode(opCode), .bitSel(bitSel),
    .memOperand(memOperand), .memWrData(memWrData), .memWrEn(memWrEn), .workReg(workReg), .carryFlag(carryFlag),
    .zeroFlag(zeroFlag), .halfCarryFlag(halfCarryFlag), .signedWrapFlag(signedWrapFlag), .skipNext(skipNext),
    .busy(busy));
  alu_rsds_mem mem (.clock(clock), .ld(ld), .ldVal(ldVal), .memWrEn(memWrEn), .memWrData(memWrData),
    .memOperand(memOperand));
  // ==========
  // Compares and counts.
  task automatic chk(input string n, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Prints the counts and the verdict.
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Loads the byte, issues one operation and waits for its answer.
  task automatic issue(input logic [3:0] op, input logic [2:0] sel, input logic [7:0] val);
    ld = 1;
    ldVal = val;
    @(negedge clock);
    ld = 0;
    opValid = 1;
    opCode = alu_rsds_pkg::op_type'(op[2:0]);
    bitSel = sel;
    @(negedge clock);
    opValid = 0;
  endtask
  // Rows: op, bit, byte, work, {carry, store, skip, 0}, {zero, half, wrap, 0}, store data.
  initial begin
    rows = '{40'h1_0_03_01_8_0_00, 40'h2_0_01_00_8_c_00, 40'h1_0_02_81_0_c_00, 40'h3_0_01_81_c_2_7f,
      40'h2_0_90_f1_0_4_00, 40'h2_0_00_f0_8_4_00, 40'h5_0_01_00_a_4_00, 40'h5_0_05_04_8_4_00,
      40'h4_0_01_04_e_4_00, 40'h4_0_00_04_c_4_ff, 40'h6_0_12_04_c_4_ff, 40'h7_7_12_04_c_4_92,
      40'h7_0_12_04_c_4_13, 40'h0_0_12_04_8_4_00};
    repeat (2) @(negedge clock);
    rst_n = 1;
    chk("reset", {workReg, carryFlag, busy, skipNext, memWrEn, zeroFlag, halfCarryFlag, signedWrapFlag}, 0);
    $display("reset test done");
    foreach (rows[i]) begin
      issue(rows[i][39:36], rows[i][34:32], rows[i][31:24]);
      chk("result", {workReg, carryFlag, memWrEn, skipNext, busy}, {rows[i][23:13], rows[i][13]});
      chk("flags", {zeroFlag, halfCarryFlag, signedWrapFlag}, rows[i][11:9]);
      if (rows[i][14]) chk("store", memWrData, rows[i][7:0]);
      $display("row %0d done", i);
    end
    ld = 1;
    ldVal = 8'h01;
    @(negedge clock);
    ld = 0;
    opValid = 1;
    opCode = alu_rsds_pkg::OP_DEC_SKIP_ZERO_MEM;
    @(negedge clock);
    opCode = alu_rsds_pkg::OP_SET_BYTE;
    chk("skip", {busy, skipNext}, 2'b11);
    @(negedge clock);
    opValid = 0;
    chk("ignored", {busy, memWrEn}, 0);
    rst_n = 0;
    @(negedge clock);
    rst_n = 1;
    chk("rereset", {workReg, carryFlag, busy, zeroFlag, halfCarryFlag}, 0);
    $display("awkward cases done");
    tally_and_finish();
  end
  // Cuts a hang short.
  initial begin
    #5000;
    errors++;
    tally_and_finish();
  end
endmodule
